//--- verilog/obd_pkg.sv
// Constants shared by the option byte decoder files
//
// Overview of operation
// - Option bytes change only through the programmer port; software cannot write them.
// - Power-up boot select 0 with an ISP region boots from the ISP region.
// - Power-up boot select 1 boots from the application region at power-up.
// - Pin-reset boot select 0 with ISP region also boots ISP after pin reset.
// - Pin-reset boot select 1 leaves the boot choice to the power-up select.
// - Scramble option 0 scrambles code read out by the programmer; 1 does not.
// - Lock option 0 locks code memory against readout; 1 leaves it open.
// - Three size bits pick ISP size 4K..1K, start 0x3000..0x3C00; 111 none.
// - Data region low bound equals the boundary option byte times 256.
// - Data region high bound equals ISP start address minus one.
// - Protect 0 in application region: only counter-clear of watchdog control writable.
// - Protect 0 in ISP region: only counter-clear and prescaler bits writable.
// - Protect 1: every watchdog control bit writable by software.
// - Auto-enable 0: power-up sets enable, loads idle-count and prescaler defaults.
// - Auto-enable 1: power-up leaves the watchdog control register untouched.
// - Cold-start flag set by power-up and writable by software, unaffected by warm resets.
package obd_pkg;
    // ==========================================
    // Register map
    localparam logic [7:0] OBD_OFF_WDOG_CTRL = 8'h00;
    localparam logic [7:0] OBD_OFF_STATUS = 8'h04;
    localparam logic [7:0] OBD_OFF_OPTIONS = 8'h08;
    localparam logic [7:0] OBD_OFF_DATA_REGION = 8'h0C;
    localparam logic [7:0] OBD_OFF_BOOT_ADDR = 8'h10;
    // ==========================================
    // Option byte zero fields
    localparam int OBD_OB0_SIZE_LSB = 5;
    localparam int OBD_OB0_PWR_BOOT = 3;
    localparam int OBD_OB0_PIN_BOOT = 2;
    localparam int OBD_OB0_SCRAMBLE = 1;
    localparam int OBD_OB0_LOCK = 0;
    // Option byte three fields
    localparam int OBD_OB3_WP = 7;
    localparam int OBD_OB3_AUTO_EN = 5;
    localparam int OBD_OB3_IDLE = 3;
    localparam int OBD_OB3_PS_LSB = 0;
    // ==========================================
    // Watchdog control fields
    localparam int OBD_WD_ENABLE = 5;
    localparam int OBD_WD_CLEAR = 4;
    localparam int OBD_WD_IDLE = 3;
    localparam int OBD_WD_PS_LSB = 0;
    localparam logic [7:0] OBD_WD_RESET = 8'h00;
    localparam logic [7:0] OBD_WD_MASK_ALL = 8'h3F;
    localparam logic [7:0] OBD_WD_MASK_ISP = 8'h17;
    localparam logic [7:0] OBD_WD_MASK_AP = 8'h10;
    // ==========================================
    // Status fields
    localparam int OBD_ST_COLD = 0;
    localparam int OBD_ST_BOOT_ISP = 1;
    localparam int OBD_ST_LOADED = 2;
    localparam int OBD_ST_SCRAMBLE = 3;
    localparam int OBD_ST_LOCK = 4;
    // ==========================================
    // Memory layout
    localparam logic [15:0] OBD_ISP_BASE = 16'h3000;
    localparam logic [15:0] OBD_ISP_STEP = 16'h0200;
    localparam logic [2:0] OBD_ISP_NONE = 3'h7;
    localparam logic [15:0] OBD_FLASH_TOP = 16'h3FFF;
    localparam logic [15:0] OBD_APP_START = 16'h0000;
    localparam logic [7:0] OBD_OPT_ERASED = 8'hFF;
    localparam logic [7:0] OBD_LOCKED_DATA = 8'hFF;
    localparam logic [1:0] OBD_OPT_LAST = 2'h3;
    // Arbitrary key
    localparam logic [7:0] OBD_SCRAMBLE_KEY = 8'hA5;

    typedef enum logic [1:0] {
        OBD_ST_LOAD_REQ = 2'b00,
        OBD_ST_APPLY = 2'b01,
        OBD_ST_RUN = 2'b10
    } obd_state_t;
endpackage

//--- verilog/obd_isp_decode.sv
// ISP region size decoder
`timescale 1ns/1ns
module obd_isp_decode
    import obd_pkg::*;
(
    input wire logic [2:0] size_code,
    output logic isp_present,
    output logic [15:0] isp_start
);
    // Each code step shrinks the region by one 512-byte page
    always_comb begin
        isp_present = (size_code != OBD_ISP_NONE);
        isp_start = OBD_ISP_BASE + (OBD_ISP_STEP * {13'h0000, size_code});
        if (!isp_present) begin
            isp_start = OBD_FLASH_TOP + 16'h0001;
        end
    end
endmodule

//--- verilog/obd_readout_guard.sv
// Readout filter for code dumped to the external programmer
`timescale 1ns/1ns
module obd_readout_guard
    import obd_pkg::*;
(
    input wire logic scramble_n,
    input wire logic lock_n,
    input wire logic [15:0] addr,
    input wire logic [7:0] raw,
    output logic [7:0] guarded
);
    always_comb begin
        if (!lock_n) begin
            guarded = OBD_LOCKED_DATA;
        end else if (!scramble_n) begin
            guarded = raw ^ addr[7:0] ^ OBD_SCRAMBLE_KEY;
        end else begin
            guarded = raw;
        end
    end
endmodule

//--- verilog/obd_top.sv
// Option byte decoder: loader, boot select, region bounds, watchdog control
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module obd_top
    import obd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic pin_reset,
    input wire logic soft_reset,
    input wire logic wdog_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [1:0] nvm_addr,
    output logic nvm_rd,
    output logic nvm_wr,
    output logic [7:0] nvm_wdata,
    input wire logic [7:0] nvm_rdata,
    input wire logic nvm_valid,
    input wire logic prog_en,
    input wire logic prog_opt_wr,
    input wire logic [1:0] prog_opt_addr,
    input wire logic [7:0] prog_opt_wdata,
    input wire logic [15:0] prog_code_addr,
    input wire logic [7:0] code_rdata,
    output logic [15:0] code_addr,
    output logic [7:0] prog_rdata,
    input wire logic [15:0] cpu_pc,
    output logic cpu_run,
    output logic [15:0] boot_addr,
    output logic boot_from_isp,
    output logic [15:0] data_region_low,
    output logic [15:0] data_region_high,
    output logic wdog_enable,
    output logic wdog_idle_count,
    output logic [2:0] wdog_prescale,
    output logic wdog_clear_pulse
);
    // ==========================================
    // State
    obd_state_t state_reg;
    logic [1:0] load_idx_reg;
    logic [7:0] option_byte_zero_reg;
    logic [7:0] option_byte_one_reg;
    logic [7:0] option_byte_two_reg;
    logic [7:0] option_byte_three_reg;
    logic cold_start_flag_reg;
    logic cold_pending_reg;
    logic pin_pending_reg;
    logic boot_isp_reg;
    logic loaded_reg;
    logic [7:0] watchdog_control_reg;
    logic [7:0] watchdog_control_next;
    logic wdog_clear_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [7:0] prog_rdata_reg;
    logic [15:0] data_low_reg;
    logic [15:0] data_high_reg;

    logic isp_present;
    logic [15:0] isp_start;
    logic [7:0] guarded;
    logic warm_reset;
    logic setup_phase;
    logic wr_access;
    logic [7:0] wd_mask;
    logic pc_in_isp;
    logic powerup_boot_select;
    logic pinreset_boot_select;
    logic readout_scramble;
    logic readout_lock;
    logic wdog_write_protect;
    logic wdog_auto_enable;

    assign powerup_boot_select = option_byte_zero_reg[OBD_OB0_PWR_BOOT];
    assign pinreset_boot_select = option_byte_zero_reg[OBD_OB0_PIN_BOOT];
    assign readout_scramble = option_byte_zero_reg[OBD_OB0_SCRAMBLE];
    assign readout_lock = option_byte_zero_reg[OBD_OB0_LOCK];
    assign wdog_write_protect = option_byte_three_reg[OBD_OB3_WP];
    assign wdog_auto_enable = option_byte_three_reg[OBD_OB3_AUTO_EN];
    assign warm_reset = pin_reset | soft_reset | wdog_reset;

    obd_isp_decode u_isp_decode (
        .size_code(option_byte_zero_reg[OBD_OB0_SIZE_LSB +: 3]),
        .isp_present(isp_present),
        .isp_start(isp_start)
    );

    obd_readout_guard u_readout_guard (
        .scramble_n(readout_scramble),
        .lock_n(readout_lock),
        .addr(prog_code_addr),
        .raw(code_rdata),
        .guarded(guarded)
    );

    // ==========================================
    // Option storage port
    // Only the programmer pins reach the write strobe; no register path exists
    always_comb begin
        nvm_wr = prog_en & prog_opt_wr;
        nvm_wdata = prog_opt_wdata;
        nvm_addr = prog_en ? prog_opt_addr : load_idx_reg;
        nvm_rd = (state_reg == OBD_ST_LOAD_REQ) && !prog_en;
    end

    // ==========================================
    // Loader sequence
    // Any reset reloads all four bytes before the processor runs
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= OBD_ST_LOAD_REQ;
            load_idx_reg <= 2'h0;
        end else if (clk_en) begin
            if (warm_reset) begin
                state_reg <= OBD_ST_LOAD_REQ;
                load_idx_reg <= 2'h0;
            end else begin
                case (state_reg)
                    OBD_ST_LOAD_REQ: begin
                        if (nvm_valid && !prog_en) begin
                            load_idx_reg <= load_idx_reg + 2'h1;
                            if (load_idx_reg == OBD_OPT_LAST) begin
                                state_reg <= OBD_ST_APPLY;
                            end
                        end
                    end
                    OBD_ST_APPLY: begin
                        state_reg <= OBD_ST_RUN;
                    end
                    default: begin
                        state_reg <= OBD_ST_RUN;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            option_byte_zero_reg <= OBD_OPT_ERASED;
            option_byte_one_reg <= OBD_OPT_ERASED;
            option_byte_two_reg <= OBD_OPT_ERASED;
            option_byte_three_reg <= OBD_OPT_ERASED;
        end else if (clk_en) begin
            // Held stable from here until the next reset
            if (state_reg == OBD_ST_LOAD_REQ && nvm_valid && !prog_en && !warm_reset) begin
                case (load_idx_reg)
                    2'h0: begin
                        option_byte_zero_reg <= nvm_rdata;
                    end
                    2'h1: begin
                        option_byte_one_reg <= nvm_rdata;
                    end
                    2'h2: begin
                        option_byte_two_reg <= nvm_rdata;
                    end
                    default: begin
                        option_byte_three_reg <= nvm_rdata;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            loaded_reg <= 1'b0;
        end else if (clk_en) begin
            if (warm_reset) begin
                loaded_reg <= 1'b0;
            end else if (state_reg == OBD_ST_APPLY) begin
                loaded_reg <= 1'b1;
            end
        end
    end

    // ==========================================
    // Reset cause and boot choice
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cold_pending_reg <= 1'b1;
            pin_pending_reg <= 1'b0;
        end else if (clk_en) begin
            if (warm_reset) begin
                cold_pending_reg <= 1'b0;
                pin_pending_reg <= pin_reset & ~soft_reset & ~wdog_reset;
            end else if (state_reg == OBD_ST_APPLY) begin
                cold_pending_reg <= 1'b0;
                pin_pending_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            boot_isp_reg <= 1'b0;
        end else if (clk_en) begin
            if (warm_reset) begin
                boot_isp_reg <= 1'b0;
            end else if (state_reg == OBD_ST_APPLY) begin
                if (!isp_present) begin
                    boot_isp_reg <= 1'b0;
                end else if (cold_pending_reg) begin
                    boot_isp_reg <= ~powerup_boot_select;
                end else if (pin_pending_reg) begin
                    // Pin select 1 defers to the power-up select
                    boot_isp_reg <= ~pinreset_boot_select | ~powerup_boot_select;
                end else begin
                    boot_isp_reg <= 1'b0;
                end
            end
        end
    end

    // Warm resets never touch this flag; software may write it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cold_start_flag_reg <= 1'b1;
        end else if (clk_en) begin
            if (wr_access && paddr == OBD_OFF_STATUS) begin
                cold_start_flag_reg <= pwdata[OBD_ST_COLD];
            end
        end
    end

    // ==========================================
    // Region bounds
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            data_low_reg <= 16'h0000;
            data_high_reg <= 16'h0000;
        end else if (clk_en) begin
            if (state_reg == OBD_ST_APPLY) begin
                // An odd byte value is accepted as written; page alignment is the writer's job
                data_low_reg <= {option_byte_one_reg, 8'h00};
                data_high_reg <= isp_start - 16'h0001;
            end
        end
    end

    // ==========================================
    // Watchdog control
    assign pc_in_isp = isp_present && (cpu_pc >= isp_start);
    assign setup_phase = psel & ~penable;
    assign wr_access = psel & penable & pwrite & pready;

    always_comb begin
        if (wdog_write_protect) begin
            wd_mask = OBD_WD_MASK_ALL;
        end else if (pc_in_isp) begin
            wd_mask = OBD_WD_MASK_ISP;
        end else begin
            wd_mask = OBD_WD_MASK_AP;
        end
        watchdog_control_next = (watchdog_control_reg & ~wd_mask) | (pwdata[7:0] & wd_mask);
        watchdog_control_next[OBD_WD_CLEAR] = 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            watchdog_control_reg <= OBD_WD_RESET;
        end else if (clk_en) begin
            if (state_reg == OBD_ST_APPLY && cold_pending_reg && !wdog_auto_enable) begin
                watchdog_control_reg[OBD_WD_ENABLE] <= 1'b1;
                watchdog_control_reg[OBD_WD_IDLE] <= option_byte_three_reg[OBD_OB3_IDLE];
                watchdog_control_reg[OBD_WD_PS_LSB +: 3] <=
                    option_byte_three_reg[OBD_OB3_PS_LSB +: 3];
            end else if (wr_access && paddr == OBD_OFF_WDOG_CTRL) begin
                // Auto-enable 1 leaves the register alone at power-up
                watchdog_control_reg <= watchdog_control_next;
            end
        end
    end

    // Counter clear is write-only and always allowed
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wdog_clear_reg <= 1'b0;
        end else if (clk_en) begin
            wdog_clear_reg <= wr_access && paddr == OBD_OFF_WDOG_CTRL
                && pwdata[OBD_WD_CLEAR] && wd_mask[OBD_WD_CLEAR];
        end
    end

    // ==========================================
    // Programmer readout
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prog_rdata_reg <= 8'h00;
        end else if (clk_en) begin
            prog_rdata_reg <= prog_en ? guarded : 8'h00;
        end
    end

    // ==========================================
    // APB slave
    // Read data captured in setup so the access phase needs no wait state
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (clk_en) begin
            if (setup_phase) begin
                pslverr_reg <= 1'b0;
                prdata_reg <= 32'h0000_0000;
                if (paddr == OBD_OFF_WDOG_CTRL) begin
                    prdata_reg <= {24'h000000, watchdog_control_reg};
                end else if (paddr == OBD_OFF_STATUS) begin
                    prdata_reg <= {27'h0000000, ~readout_lock, ~readout_scramble,
                        loaded_reg, boot_isp_reg, cold_start_flag_reg};
                end else if (paddr == OBD_OFF_OPTIONS) begin
                    // Read-only view; writes here are silently dropped
                    prdata_reg <= {option_byte_three_reg, option_byte_two_reg,
                        option_byte_one_reg, option_byte_zero_reg};
                end else if (paddr == OBD_OFF_DATA_REGION) begin
                    prdata_reg <= {data_high_reg, data_low_reg};
                end else if (paddr == OBD_OFF_BOOT_ADDR) begin
                    prdata_reg <= {16'h0000, boot_addr};
                end else begin
                    pslverr_reg <= 1'b1;
                end
            end
        end
    end

    // ==========================================
    // Outputs
    always_comb begin
        pready = psel & penable & clk_en;
        prdata = prdata_reg;
        pslverr = pslverr_reg & pready;
        cpu_run = (state_reg == OBD_ST_RUN);
        boot_from_isp = boot_isp_reg;
        boot_addr = boot_isp_reg ? isp_start : OBD_APP_START;
        data_region_low = data_low_reg;
        data_region_high = data_high_reg;
        wdog_enable = watchdog_control_reg[OBD_WD_ENABLE];
        wdog_idle_count = watchdog_control_reg[OBD_WD_IDLE];
        wdog_prescale = watchdog_control_reg[OBD_WD_PS_LSB +: 3];
        wdog_clear_pulse = wdog_clear_reg;
        code_addr = prog_code_addr;
        prog_rdata = prog_rdata_reg;
    end
endmodule

//--- testbench/obd_top_asserts.sv
// Port checks for the option byte decoder
`timescale 1ns/1ns
module obd_top_asserts
    import obd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic pin_reset,
    input wire logic prog_en,
    input wire logic nvm_rd,
    input wire logic nvm_wr,
    input wire logic nvm_valid,
    input wire logic [1:0] nvm_addr,
    input wire logic [7:0] prog_rdata,
    input wire logic cpu_run,
    input wire logic [15:0] boot_addr,
    input wire logic boot_from_isp,
    input wire logic [15:0] data_region_low,
    input wire logic [15:0] data_region_high,
    input wire logic wdog_clear_pulse
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // ========
    // Loader steps
    sequence s_last_byte;
        clk_en && nvm_rd && nvm_valid && nvm_addr == 2'h3 && !pin_reset;
    endsequence
    sequence s_apply_run;
        !cpu_run ##1 cpu_run;
    endsequence
    a_load_then_run: assert property (s_last_byte |=> s_apply_run)
        else $error("cpu not released after last option byte");
    a_warm_holds_cpu: assert property (pin_reset && clk_en |=> !cpu_run)
        else $error("cpu kept running through pin reset");
    a_option_write_gate: assert property (nvm_wr |-> prog_en)
        else $error("option write without programmer");
    a_load_paused: assert property (prog_en |-> !nvm_rd)
        else $error("option load while programmer connected");
    a_isp_boot_addr: assert property (cpu_run && boot_from_isp
        |-> boot_addr == data_region_high + 16'h1)
        else $error("isp boot address and high bound disagree");
    a_app_boot_addr: assert property (cpu_run && !boot_from_isp
        |-> boot_addr == 16'h0000)
        else $error("application boot address not zero");
    a_low_bound_page: assert property (cpu_run |-> data_region_low[7:0] == 8'h00)
        else $error("low bound not a multiple of 256");
    a_high_bound_step: assert property (cpu_run
        |-> data_region_high[8:0] == 9'h1FF && data_region_high >= 16'h2FFF)
        else $error("high bound off the isp grid");
    a_readout_idle: assert property (!prog_en && clk_en |=> prog_rdata == 8'h00)
        else $error("readout data without programmer");
    a_clear_one_shot: assert property ($rose(wdog_clear_pulse) && clk_en
        |=> !wdog_clear_pulse)
        else $error("clear pulse longer than one cycle");
endmodule
bind obd_top obd_top_asserts obd_top_asserts_inst (.sys_clk(sys_clk), .rstn(rstn),
    .clk_en(clk_en), .pin_reset(pin_reset), .prog_en(prog_en), .nvm_rd(nvm_rd),
    .nvm_wr(nvm_wr), .nvm_valid(nvm_valid), .nvm_addr(nvm_addr), .prog_rdata(prog_rdata),
    .cpu_run(cpu_run), .boot_addr(boot_addr), .boot_from_isp(boot_from_isp),
    .data_region_low(data_region_low), .data_region_high(data_region_high),
    .wdog_clear_pulse(wdog_clear_pulse));

//--- testbench/obd_nvm_model.sv
// Option byte storage behind the programmer pins
`timescale 1ns/1ns
module obd_nvm_model (
    input wire logic sys_clk,
    input wire logic slow,
    input wire logic [1:0] nvm_addr,
    input wire logic nvm_rd,
    input wire logic nvm_wr,
    input wire logic [7:0] nvm_wdata,
    output logic [7:0] nvm_rdata,
    output logic nvm_valid
);
    logic [7:0] mem_reg [4];
    logic [7:0] last_reg;
    logic tick_reg;
    initial begin
        mem_reg = '{8'hFF, 8'hFF, 8'hFF, 8'hFF};
        last_reg = 8'h00;
        tick_reg = 1'b0;
    end
    always @(posedge sys_clk) begin
        if (nvm_wr) begin
            mem_reg[nvm_addr] <= nvm_wdata;
        end
        if (nvm_valid) begin
            last_reg <= mem_reg[nvm_addr];
        end
        tick_reg <= ~tick_reg;
    end
    // Slow mode answers every other cycle; idle data never repeats the last byte
    assign nvm_valid = nvm_rd && (!slow || tick_reg);
    assign nvm_rdata = nvm_valid ? mem_reg[nvm_addr] : ~last_reg;
endmodule

//--- testbench/tb_obd_top.sv
// Self-checking bench for the option byte decoder
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin failures++; \
    $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp); end end
module tb_obd_top;
    import obd_pkg::*;
    logic sys_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, pin_reset = 1'b0, soft_reset = 1'b0;
    logic wdog_reset = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic prog_en = 1'b0, prog_opt_wr = 1'b0, pready, pslverr, nvm_rd, nvm_wr, nvm_valid;
    logic [7:0] paddr = 8'h00, prog_opt_wdata = 8'h00, code_rdata = 8'h3C;
    logic [1:0] prog_opt_addr = 2'h0, nvm_addr;
    logic [15:0] prog_code_addr = 16'h0123, cpu_pc = 16'h0000, exp;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [7:0] nvm_wdata, nvm_rdata, prog_rdata, modes [5] = '{8'h1F, 8'h1B, 8'h17, 8'h13, 8'hFB};
    logic [15:0] code_addr, boot_addr, data_region_low, data_region_high;
    logic [4:0] pwr_exp = 5'h0C, pin_exp = 5'h0E;
    logic [7:0] g_opt [3] = '{8'h1D, 8'h1E, 8'h1F};
    logic [7:0] g_exp [3] = '{8'h3C ^ 8'h23 ^ OBD_SCRAMBLE_KEY, 8'hFF, 8'h3C};
    logic cpu_run, boot_from_isp, wdog_enable, wdog_idle_count, wdog_clear_pulse, rerr;
    logic [2:0] wdog_prescale;
    int failures = 0, num_checks = 0;
    always #25 sys_clk = ~sys_clk;
    obd_top obd_top_inst (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .pin_reset(pin_reset),
        .soft_reset(soft_reset), .wdog_reset(wdog_reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nvm_addr(nvm_addr), .nvm_rd(nvm_rd), .nvm_wr(nvm_wr),
        .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata), .nvm_valid(nvm_valid), .prog_en(prog_en),
        .prog_opt_wr(prog_opt_wr), .prog_opt_addr(prog_opt_addr), .prog_opt_wdata(prog_opt_wdata),
        .prog_code_addr(prog_code_addr), .code_rdata(code_rdata), .code_addr(code_addr),
        .prog_rdata(prog_rdata), .cpu_pc(cpu_pc), .cpu_run(cpu_run), .boot_addr(boot_addr),
        .boot_from_isp(boot_from_isp), .data_region_low(data_region_low),
        .data_region_high(data_region_high), .wdog_enable(wdog_enable),
        .wdog_idle_count(wdog_idle_count), .wdog_prescale(wdog_prescale),
        .wdog_clear_pulse(wdog_clear_pulse));
    obd_nvm_model obd_nvm_model_inst (.sys_clk(sys_clk), .slow(slow), .nvm_addr(nvm_addr),
        .nvm_rd(nvm_rd), .nvm_wr(nvm_wr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata),
        .nvm_valid(nvm_valid));
    // ========
    // Access tasks
    task automatic end_of_test();
        if (failures == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wait_run();
        int n;
        n = 0;
        while (cpu_run !== 1'b1 && n < 50) begin
            n++;
            @(posedge sys_clk);
        end
        `CHK(cpu_run, 1'b1, "cpu released");
    endtask
    // Options only reach storage through the programmer pins, then a power-up
    task automatic boot(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b3);
        logic [7:0] ob [4];
        ob = '{b0, b1, 8'hFF, b3};
        prog_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            prog_opt_wr <= 1'b1;
            prog_opt_addr <= 2'(i);
            prog_opt_wdata <= ob[i];
        end
        @(posedge sys_clk);
        prog_opt_wr <= 1'b0;
        prog_en <= 1'b0;
        rstn <= 1'b0;
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        wait_run();
    endtask
    task automatic warm();
        pin_reset <= 1'b1;
        @(posedge sys_clk);
        pin_reset <= 1'b0;
        @(posedge sys_clk);
        wait_run();
    endtask
    // ========
    // Scenarios
    initial begin
        #1000000;
        failures++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        wait_run();
        for (int c = 0; c < 8; c++) begin
            slow <= c[0];
            boot({c[2:0], 5'h13}, 8'h12, 8'hFF);
            exp = (c == 7) ? 16'h3FFF : OBD_ISP_BASE + 16'(c) * OBD_ISP_STEP - 16'h1;
            `CHK(boot_from_isp, (c != 7), "isp boot");
            `CHK(data_region_high, exp, "high bound");
            `CHK(data_region_low, 16'h1200, "low bound");
            `CHK(wdog_enable, 1'b0, "no auto enable");
        end
        for (int k = 0; k < 5; k++) begin
            boot(modes[k], 8'h20, 8'h5D);
            `CHK(boot_from_isp, pwr_exp[k], "power boot");
            warm();
            `CHK(boot_from_isp, pin_exp[k], "pin boot");
        end
        boot(8'h13, 8'h20, 8'h5D);
        apb(1'b0, OBD_OFF_WDOG_CTRL, 32'h0);
        `CHK(rdata, 32'h2D, "auto enable load");
        `CHK(wdog_idle_count, 1'b1, "idle default");
        `CHK(wdog_prescale, 3'h5, "prescale default");
        apb(1'b1, OBD_OFF_WDOG_CTRL, 32'h10);
        `CHK(wdog_clear_pulse, 1'b1, "clear pulse");
        apb(1'b0, OBD_OFF_WDOG_CTRL, 32'h0);
        `CHK(rdata, 32'h2D, "app protect");
        cpu_pc <= 16'h3800;
        apb(1'b1, OBD_OFF_WDOG_CTRL, 32'h0);
        apb(1'b0, OBD_OFF_WDOG_CTRL, 32'h0);
        `CHK(rdata, 32'h28, "isp protect");
        apb(1'b0, OBD_OFF_STATUS, 32'h0);
        `CHK(rdata[0], 1'b1, "cold after power");
        apb(1'b1, OBD_OFF_STATUS, 32'h0);
        warm();
        apb(1'b0, OBD_OFF_STATUS, 32'h0);
        `CHK(rdata[0], 1'b0, "cold kept by pin reset");
        clk_en <= 1'b0;
        pin_reset <= 1'b1;
        @(posedge sys_clk);
        pin_reset <= 1'b0;
        @(posedge sys_clk);
        `CHK(cpu_run, 1'b1, "frozen by enable");
        clk_en <= 1'b1;
        boot(8'h13, 8'h20, 8'hDD);
        apb(1'b1, OBD_OFF_WDOG_CTRL, 32'h0);
        apb(1'b0, OBD_OFF_WDOG_CTRL, 32'h0);
        `CHK(rdata, 32'h0, "free write");
        apb(1'b1, OBD_OFF_OPTIONS, 32'h0);
        apb(1'b0, OBD_OFF_OPTIONS, 32'h0);
        `CHK(rdata, 32'hDDFF2013, "options read only");
        apb(1'b1, 8'h40, 32'hFFFFFFFF);
        `CHK(rerr, 1'b1, "unmapped error");
        for (int k = 0; k < 3; k++) begin
            boot(g_opt[k], 8'h20, 8'hFF);
            prog_en <= 1'b1;
            repeat (3) @(posedge sys_clk);
            `CHK(prog_rdata, g_exp[k], "readout");
            `CHK(code_addr, 16'h0123, "code address");
        end
        end_of_test();
    end
endmodule
